/* File: hdl/cie_pkg.sv */
// Constants of the control instruction execution block: register map,
// command codes, processor status layout, reset values and cycle counts.
// Assumes a 40 MHz core clock; every cycle count below is in core clock cycles.
package cie_pkg;
  // APB register byte offsets
  localparam logic [7:0] CMD_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] ACC_OFS = 8'h08;
  localparam logic [7:0] SP_OFS = 8'h0C;
  localparam logic [7:0] PC_OFS = 8'h10;
  localparam logic [7:0] PS_OFS = 8'h14;
  localparam logic [7:0] LIM_OFS = 8'h18;
  localparam logic [7:0] BRGL_OFS = 8'h1C;
  localparam logic [7:0] BRGH_OFS = 8'h20;
  // Word registers: base + 4 * {bank, n}
  localparam logic [7:0] RWB_OFS = 8'h80;
  // Command word fields
  localparam int CMD_IM8 = 8;
  localparam int CMD_IM16 = 16;
  // Status register fields
  localparam int ST_FAULT = 2;
  // Processor status fields
  localparam int PS_Z = 2;
  localparam int PS_N = 3;
  localparam int PS_RP = 8;
  localparam int PS_ILM = 13;
  // Reset values and fixed addresses
  localparam logic [15:0] SP_RST = 16'h0080;
  localparam logic [15:0] PS_RST = 16'h0000;
  localparam logic [15:0] STACK_LIMIT_UPPER_RST = 16'hFFFF;
  localparam logic [15:0] STACK_LIMIT_LOWER_RST = 16'h0000;
  localparam logic [15:0] VEC_PC = 16'h0100;
  localparam logic [1:0] CMN_BANK = 2'h0;
  localparam int STK_WORDS = 64;
  // Address space codes
  localparam logic [2:0] SPC_ADB = 3'h1;
  localparam logic [2:0] SPC_DTB = 3'h2;
  localparam logic [2:0] SPC_PCB = 3'h3;
  localparam logic [2:0] SPC_SPB = 3'h4;
  localparam logic [2:0] SPC_USB = 3'h5;
  localparam logic [2:0] SPC_SSB = 3'h6;
  localparam logic [2:0] SPC_DPR = 3'h7;
  // Command codes
  localparam logic [7:0] OP_NOP = 8'h00, OP_PUSH_A = 8'h01, OP_PUSH_AH = 8'h02, OP_PUSH_PS = 8'h03;
  localparam logic [7:0] OP_PUSH_LST = 8'h04, OP_POP_A = 8'h05, OP_POP_AH = 8'h06, OP_POP_PS = 8'h07;
  localparam logic [7:0] OP_POP_LST = 8'h08, OP_AND_CCR = 8'h09, OP_OR_CCR = 8'h0A, OP_MOV_RP = 8'h0B;
  localparam logic [7:0] OP_MOV_ILM = 8'h0C, OP_LEA_RW = 8'h0D, OP_LEA_RWM = 8'h0E, OP_LEA_A = 8'h0F;
  localparam logic [7:0] OP_LEA_AM = 8'h10, OP_SPADJ8 = 8'h11, OP_SPADJ16 = 8'h12, OP_A_BRG = 8'h13;
  localparam logic [7:0] OP_BRG_A = 8'h14, OP_BRG_IMM = 8'h15, OP_PFX_ADB = 8'h16, OP_PFX_DTB = 8'h17;
  localparam logic [7:0] OP_PFX_PCB = 8'h18, OP_PFX_SPB = 8'h19, OP_PFX_USB = 8'h1A, OP_PFX_SSB = 8'h1B;
  localparam logic [7:0] OP_PFX_DPR = 8'h1C, OP_PFX_NCC = 8'h1D, OP_PFX_CMR = 8'h1E, OP_LD_STACK_LIMIT_UPPER = 8'h1F;
  localparam logic [7:0] OP_LD_STACK_LIMIT_LOWER = 8'h20, OP_CHK_ON = 8'h21, OP_CHK_OFF = 8'h22, OP_BSCAN = 8'h23;
  localparam logic [7:0] OP_BSCAN2 = 8'h24, OP_BSCAN4 = 8'h25, OP_FRETI = 8'h26, OP_BCOND = 8'h27;
  // Cycle counts
  localparam logic [7:0] CYC_PUSH = 8'h03, CYC_POP = 8'h03, CYC_LST_BASE = 8'h03, CYC_LST_PER = 8'h04;
  localparam logic [7:0] CYC_CCR = 8'h03, CYC_RPILM = 8'h02, CYC_LEA_RW = 8'h03, CYC_LEA_RWM = 8'h02;
  localparam logic [7:0] CYC_LEA_A = 8'h02, CYC_LEA_AM = 8'h01, CYC_EA_CORR = 8'h01, CYC_SPADJ = 8'h03;
  localparam logic [7:0] CYC_A_BRG = 8'h02, CYC_BRG_A = 8'h01, CYC_BRG_IMM = 8'h02, CYC_NOP = 8'h01;
  localparam logic [7:0] CYC_PFX = 8'h01, CYC_PFX_DT = 8'h02, CYC_PFX_DP = 8'h03, CYC_LIM = 8'h02;
  localparam logic [7:0] CYC_CHK = 8'h02, CYC_BSC_Z = 8'h03, CYC_BSC = 8'h05, CYC_BSC2_Z = 8'h04;
  localparam logic [7:0] CYC_BSC2 = 8'h06, CYC_BSC4_Z = 8'h05, CYC_BSC4 = 8'h07, CYC_BR_T = 8'h04;
  localparam logic [7:0] CYC_BR_N = 8'h03, CYC_RETI = 8'h06;
  // Execution states
  typedef enum logic [1:0] {CIE_IDLE = 2'b01, CIE_RUN = 2'b10} cie_state_t;
endpackage : cie_pkg

/* File: hdl/cie_scan.sv */
// Lowest set bit finder used for the bit scan and register list walks.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps
module cie_scan
  import cie_pkg::*;
(
  input wire logic [15:0] word,
  output logic [3:0] pos,
  output logic found
);
  // Scan from the top so the lowest set bit wins
  always_comb begin
    pos = 4'h0;
    for (int i = 15; i >= 0; i--) begin
      if (word[i]) begin
        pos = 4'(i);
      end
    end
  end
  // Nothing set means position zero is not a real hit
  assign found = |word;
endmodule : cie_scan

/* File: hdl/cie_timer.sv */
// Down counter that times one instruction in core clock cycles.
// Expects load only while idle; last marks the final cycle.
`timescale 1ns/1ps
module cie_timer
  import cie_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic load,
  input wire logic [7:0] load_val,
  output logic last
);
  logic [7:0] cnt_reg; // Cycles still to run
  // Load on start, otherwise count down to zero
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_reg <= 8'h00;
    end else if (load) begin
      cnt_reg <= load_val;
    end else if (cnt_reg != 8'h00) begin
      cnt_reg <= cnt_reg - 8'h01;
    end
  end
  assign last = (cnt_reg == 8'h01);
endmodule : cie_timer

/* File: hdl/cie_core.sv */
// Control instruction execution unit with an APB register slave.
// Software issues one command word at a time; APB is the only access path.
`timescale 1ns/1ps
module cie_core
  import cie_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic irq_req
);
  cie_state_t state_reg, state_next;
  logic [31:0] cmd_reg; // Command in execution
  logic [31:0] acc_reg; // Accumulator, AH in the top half
  logic [15:0] sp_reg, pc_reg, ps_reg, ps_next, stack_limit_upper_reg, stack_limit_lower_reg;
  logic chk_reg, fault_reg, keep_reg, cmn_reg, pspv_reg, irq_hit_reg;
  logic [2:0] pspc_reg, aspc_reg; // Pending and last used space
  logic [7:0] lst_reg; // Register list still to walk
  logic [7:0] brg_reg [0:7]; // Bank registers
  logic [15:0] rw_mem [0:31]; // Four banks of eight words
  logic [15:0] stk_mem [0:STK_WORDS-1]; // Stack memory
  logic [31:0] prdata_reg;
  logic pready_reg, pslverr_reg;

  // APB decode
  wire setup = psel & ~penable;
  wire acc_ph = psel & penable & pready_reg;
  wire a_cmd = (paddr == CMD_OFS);
  wire a_stat = (paddr == STAT_OFS);
  wire a_acc = (paddr == ACC_OFS);
  wire a_sp = (paddr == SP_OFS);
  wire a_pc = (paddr == PC_OFS);
  wire a_ps = (paddr == PS_OFS);
  wire a_ro = (paddr == LIM_OFS) | (paddr == BRGL_OFS) | (paddr == BRGH_OFS);
  wire a_rw = paddr[7] & (paddr[1:0] == 2'b00);
  wire mapped = a_cmd | a_stat | a_acc | a_sp | a_pc | a_ps | a_ro | a_rw;
  wire busy = (state_reg == CIE_RUN);
  // Software writes are refused while an instruction runs, except to the status register
  wire err_w = ~mapped | (pwrite & busy & ~a_stat) | (pwrite & a_ro);
  wire wr = acc_ph & pwrite & ~pslverr_reg;
  wire start = wr & a_cmd;
  wire [4:0] rw_sw_idx = paddr[6:2];

  // Command fields
  wire [7:0] op = cmd_reg[7:0];
  wire [7:0] im8 = cmd_reg[CMD_IM8 +: 8];
  wire [15:0] im16 = cmd_reg[CMD_IM16 +: 16];
  wire [7:0] condition_code_byte = ps_reg[7:0];
  wire tlast;
  wire com = busy & tlast; // Commit edge of the running instruction

  // Operation classes
  wire is_push1 = (op == OP_PUSH_A) | (op == OP_PUSH_AH) | (op == OP_PUSH_PS);
  wire is_pop1 = (op == OP_POP_A) | (op == OP_POP_AH) | (op == OP_POP_PS);
  wire is_bsc = (op == OP_BSCAN) | (op == OP_BSCAN2) | (op == OP_BSCAN4);
  wire is_pfx = (op >= OP_PFX_ADB) & (op <= OP_PFX_CMR);
  wire is_stk = is_push1 | is_pop1 | (op == OP_PUSH_LST) | (op == OP_POP_LST) | (op == OP_FRETI);
  wire lst_push = (op == OP_PUSH_LST);
  wire lst_pop = (op == OP_POP_LST);
  wire [1:0] bank = cmn_reg ? CMN_BANK : ps_reg[PS_RP +: 2];
  // prefix chooses the space of the stack access
  wire [2:0] sp_space = pspv_reg ? pspc_reg : SPC_SPB;

  // Stack arithmetic and limit checks
  wire [15:0] sp_dn = sp_reg - 16'h0002;
  wire [15:0] sp_up = sp_reg + 16'h0002;
  wire bad_dn = chk_reg & (sp_dn < stack_limit_lower_reg);
  wire bad_up = chk_reg & (sp_up > stack_limit_upper_reg);
  wire [15:0] top_val = stk_mem[sp_reg[6:1]];
  wire [15:0] top2_val = stk_mem[sp_up[6:1]];
  wire [15:0] push_val = (op == OP_PUSH_A) ? acc_reg[15:0] : (op == OP_PUSH_AH) ? acc_reg[31:16] : ps_reg;

  // Register list walk: pushes go highest first, pops lowest first
  logic [7:0] lst_rev;
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_rev
      assign lst_rev[gi] = lst_reg[7 - gi];
    end
  endgenerate
  logic [3:0] lpos, apos;
  logic lfound, afound;
  cie_scan u_lscan (
    .word({8'h00, lst_push ? lst_rev : lst_reg}),
    .pos(lpos),
    .found(lfound)
  );
  wire [2:0] lreg = lst_push ? (3'h7 - lpos[2:0]) : lpos[2:0];
  wire lst_step = busy & lfound;
  wire lst_bad = lst_push ? bad_dn : bad_up;
  wire [4:0] lst_idx = {bank, lreg};

  // Stack memory and pointer control
  wire stk_we = (com & is_push1 & ~bad_dn) | (lst_step & lst_push & ~lst_bad);
  wire pop_ok = (com & is_pop1 & ~bad_up) | (lst_step & lst_pop & ~lst_bad);
  wire [15:0] stk_wd = lst_step ? rw_mem[lst_idx] : push_val;
  wire fault_set = (com & is_push1 & bad_dn) | (com & is_pop1 & bad_up) | (lst_step & lst_bad);
  wire irq_seen = irq_hit_reg | irq_req;

  // Bit scan of the accumulator low word
  cie_scan u_ascan (
    .word(acc_reg[15:0]),
    .pos(apos),
    .found(afound)
  );
  wire [7:0] scan_res = ~afound ? 8'h00 : (op == OP_BSCAN) ? {4'h0, apos} :
    (op == OP_BSCAN2) ? {3'h0, apos, 1'b0} : {2'h0, apos, 2'b00};
  wire al_zero = (acc_reg[15:0] == 16'h0000);

  // Branch condition: flag chosen by im8[2:0] equal to im8[3]
  wire br_taken = (condition_code_byte[im8[2:0]] == im8[3]);
  wire new_taken = (condition_code_byte[pwdata[CMD_IM8 +: 3]] == pwdata[CMD_IM8 + 3]);
  wire [7:0] brg_src = (im8[2:0] <= 3'h5) ? brg_reg[im8[2:0]] : 8'h00;
  wire brg_tgt_ok = (im8[2:0] <= 3'h4);

  // Instruction length in cycles
  function automatic logic [7:0] cyc_of(input logic [31:0] c, input logic z, input logic tk);
    logic [7:0] k;
    k = 8'h00;
    for (int i = 0; i < 8; i++) begin
      k = k + {7'h00, c[CMD_IM8 + i]};
    end
    case (c[7:0])
      OP_PUSH_A, OP_PUSH_AH, OP_PUSH_PS: cyc_of = CYC_PUSH;
      OP_POP_A, OP_POP_AH, OP_POP_PS: cyc_of = CYC_POP;
      OP_PUSH_LST, OP_POP_LST: cyc_of = CYC_LST_BASE + CYC_LST_PER * k;
      OP_AND_CCR, OP_OR_CCR: cyc_of = CYC_CCR;
      OP_MOV_RP, OP_MOV_ILM: cyc_of = CYC_RPILM;
      OP_LEA_RW: cyc_of = CYC_LEA_RW;
      OP_LEA_RWM: cyc_of = CYC_LEA_RWM + CYC_EA_CORR;
      OP_LEA_A: cyc_of = CYC_LEA_A;
      OP_LEA_AM: cyc_of = CYC_LEA_AM + CYC_EA_CORR;
      OP_SPADJ8, OP_SPADJ16: cyc_of = CYC_SPADJ;
      OP_A_BRG: cyc_of = CYC_A_BRG;
      OP_BRG_A: cyc_of = CYC_BRG_A;
      OP_BRG_IMM: cyc_of = CYC_BRG_IMM;
      OP_PFX_DTB: cyc_of = CYC_PFX_DT;
      OP_PFX_DPR: cyc_of = CYC_PFX_DP;
      OP_PFX_ADB, OP_PFX_PCB, OP_PFX_SPB, OP_PFX_USB, OP_PFX_SSB, OP_PFX_NCC, OP_PFX_CMR: cyc_of = CYC_PFX;
      OP_LD_STACK_LIMIT_UPPER, OP_LD_STACK_LIMIT_LOWER: cyc_of = CYC_LIM;
      OP_CHK_ON, OP_CHK_OFF: cyc_of = CYC_CHK;
      // scan time depends on a zero word
      OP_BSCAN: cyc_of = z ? CYC_BSC_Z : CYC_BSC;
      OP_BSCAN2: cyc_of = z ? CYC_BSC2_Z : CYC_BSC2;
      OP_BSCAN4: cyc_of = z ? CYC_BSC4_Z : CYC_BSC4;
      OP_BCOND: cyc_of = tk ? CYC_BR_T : CYC_BR_N;
      OP_FRETI: cyc_of = CYC_RETI;
      // no-operation and unknown codes, one cycle
      default: cyc_of = CYC_NOP;
    endcase
  endfunction : cyc_of

  cie_timer u_timer (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .load(start),
    .load_val(cyc_of(pwdata, al_zero, new_taken)),
    .last(tlast)
  );

  // Sequencer
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      CIE_IDLE: if (start) state_next = CIE_RUN;
      CIE_RUN: if (tlast) state_next = CIE_IDLE;
      default: state_next = CIE_IDLE;
    endcase
  end

  // Processor status next value
  always_comb begin
    ps_next = ps_reg;
    if (wr & a_ps) begin
      ps_next = pwdata[15:0];
    end else if (com) begin
      case (op)
        OP_POP_PS: if (!bad_up) ps_next = top_val;
        OP_AND_CCR: ps_next[7:0] = condition_code_byte & im8;
        OP_OR_CCR: ps_next[7:0] = condition_code_byte | im8;
        OP_MOV_RP: ps_next[PS_RP +: 5] = im8[4:0];
        OP_MOV_ILM: ps_next[PS_ILM +: 3] = im8[2:0];
        OP_FRETI: if (!irq_seen) ps_next = top2_val;
        default: ps_next = ps_reg;
      endcase
      // flag updates dropped after keep-flags prefix
      if (!keep_reg) begin
        // N and Z from the moved byte; a scan sets only Z, from the scanned word
        if (op == OP_A_BRG) begin
          ps_next[PS_N] = brg_src[7];
          ps_next[PS_Z] = (brg_src == 8'h00);
        end else if (op == OP_BRG_A) begin
          ps_next[PS_N] = acc_reg[7];
          ps_next[PS_Z] = (acc_reg[7:0] == 8'h00);
        end else if (op == OP_BRG_IMM) begin
          ps_next[PS_N] = im16[7];
          ps_next[PS_Z] = (im16[7:0] == 8'h00);
        end else if (is_bsc) begin
          ps_next[PS_Z] = al_zero;
        end
      end
    end
  end

  // APB answer: data and error captured in setup, ready in access
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= setup;
      if (setup) begin
        pslverr_reg <= err_w;
        prdata_reg <= (pwrite | err_w) ? 32'h0000_0000 : a_cmd ? cmd_reg :
          a_stat ? {17'h0, pspc_reg, 1'b0, aspc_reg, 2'b00, pspv_reg, cmn_reg, keep_reg, fault_reg, chk_reg, busy} :
          a_acc ? acc_reg : a_sp ? {16'h0, sp_reg} : a_pc ? {16'h0, pc_reg} : a_ps ? {16'h0, ps_reg} :
          (paddr == LIM_OFS) ? {stack_limit_upper_reg, stack_limit_lower_reg} :
          (paddr == BRGL_OFS) ? {brg_reg[3], brg_reg[2], brg_reg[1], brg_reg[0]} :
          (paddr == BRGH_OFS) ? {brg_reg[7], brg_reg[6], brg_reg[5], brg_reg[4]} : {16'h0, rw_mem[rw_sw_idx]};
      end
    end
  end

  // Control and pointer registers
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= CIE_IDLE;
      cmd_reg <= 32'h0000_0000;
      ps_reg <= PS_RST;
      sp_reg <= SP_RST;
      pc_reg <= 16'h0000;
      lst_reg <= 8'h00;
      irq_hit_reg <= 1'b0;
      fault_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      ps_reg <= ps_next;
      if (start) begin
        cmd_reg <= pwdata;
        lst_reg <= pwdata[CMD_IM8 +: 8] & {8{(pwdata[7:0] == OP_PUSH_LST) | (pwdata[7:0] == OP_POP_LST)}};
      end else if (lst_step) begin
        lst_reg[lreg] <= 1'b0;
      end
      // remember an interrupt seen during fast return
      irq_hit_reg <= start ? 1'b0 : (irq_hit_reg | (busy & (op == OP_FRETI) & irq_req));
      // Hardware fault set wins over the software clear
      fault_reg <= fault_set | (fault_reg & ~(wr & a_stat & pwdata[ST_FAULT]));
      if (wr & a_sp) sp_reg <= pwdata[15:0];
      else if (stk_we) sp_reg <= sp_dn;
      else if (pop_ok) sp_reg <= sp_up;
      else if (com & (op == OP_SPADJ8)) sp_reg <= sp_reg + {{8{im8[7]}}, im8};
      else if (com & (op == OP_SPADJ16)) sp_reg <= sp_reg + im16;
      else if (com & (op == OP_FRETI) & ~irq_seen) sp_reg <= sp_up + 16'h0002;
      if (wr & a_pc) pc_reg <= pwdata[15:0];
      else if (com & (op == OP_BCOND) & br_taken) pc_reg <= pc_reg + {{8{im16[7]}}, im16[7:0]};
      else if (com & (op == OP_FRETI)) pc_reg <= irq_seen ? VEC_PC : top_val;
    end
  end

  // Prefix, limit and check state
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      {keep_reg, cmn_reg, pspv_reg, chk_reg} <= 4'h0;
      pspc_reg <= SPC_SPB;
      aspc_reg <= SPC_SPB;
      stack_limit_upper_reg <= STACK_LIMIT_UPPER_RST;
      stack_limit_lower_reg <= STACK_LIMIT_LOWER_RST;
    end else if (com) begin
      if (is_stk) aspc_reg <= sp_space;
      if (!is_pfx) {keep_reg, cmn_reg, pspv_reg} <= 3'h0;
      if (is_pfx & (op <= OP_PFX_DPR)) begin
        pspv_reg <= 1'b1;
        pspc_reg <= (op == OP_PFX_ADB) ? SPC_ADB : (op == OP_PFX_DTB) ? SPC_DTB : (op == OP_PFX_PCB) ? SPC_PCB :
          (op == OP_PFX_SPB) ? SPC_SPB : (op == OP_PFX_USB) ? SPC_USB : (op == OP_PFX_SSB) ? SPC_SSB : SPC_DPR;
      end
      if (op == OP_PFX_NCC) keep_reg <= 1'b1;
      if (op == OP_PFX_CMR) cmn_reg <= 1'b1;
      if (op == OP_LD_STACK_LIMIT_UPPER) stack_limit_upper_reg <= im16;
      if (op == OP_LD_STACK_LIMIT_LOWER) stack_limit_lower_reg <= im16;
      if (op == OP_CHK_ON) chk_reg <= 1'b1;
      if (op == OP_CHK_OFF) chk_reg <= 1'b0;
    end
  end

  // Accumulator and bank registers
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      acc_reg <= 32'h0000_0000;
      for (int i = 0; i < 8; i++) brg_reg[i] <= 8'h00;
    end else if (wr & a_acc) begin
      acc_reg <= pwdata;
    end else if (com) begin
      case (op)
        OP_POP_A: if (!bad_up) acc_reg[15:0] <= top_val;
        OP_POP_AH: if (!bad_up) acc_reg[31:16] <= top_val;
        // address itself is loaded, old AL moves up
        OP_LEA_A, OP_LEA_AM: acc_reg <= {acc_reg[15:0], im16};
        OP_A_BRG: acc_reg <= {acc_reg[15:0], 8'h00, brg_src};
        // scan result with the upper byte cleared
        OP_BSCAN, OP_BSCAN2, OP_BSCAN4: acc_reg[15:0] <= {8'h00, scan_res};
        OP_BRG_A: if (brg_tgt_ok) brg_reg[im8[2:0]] <= acc_reg[7:0];
        OP_BRG_IMM: if (brg_tgt_ok) brg_reg[im8[2:0]] <= im16[7:0];
        default: acc_reg <= acc_reg;
      endcase
    end
  end

  // Memories: stack words and banked word registers
  always_ff @(posedge core_clk) begin
    if (stk_we) stk_mem[sp_dn[6:1]] <= stk_wd;
    if (wr & a_rw) rw_mem[rw_sw_idx] <= pwdata[15:0];
    else if (lst_step & lst_pop & ~lst_bad) rw_mem[lst_idx] <= top_val;
    else if (com & ((op == OP_LEA_RW) | (op == OP_LEA_RWM))) rw_mem[{bank, im8[2:0]}] <= im16;
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;

  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  wire new_op_nop = start & (pwdata[7:0] == OP_NOP);
  wire new_br_t = start & (pwdata[7:0] == OP_BCOND) & new_taken;
  nop_len_a: assert property (new_op_nop |=> busy ##1 !busy) else $error("nop not one cycle");
  push_sp_a: assert property (com & is_push1 & ~bad_dn |=> sp_reg == $past(sp_dn)) else $error("push sp");
  pop_sp_a: assert property (com & is_pop1 & ~bad_up |=> sp_reg == $past(sp_up)) else $error("pop sp");
  ccr_and_a: assert property (com && op == OP_AND_CCR |=> condition_code_byte == ($past(condition_code_byte) & $past(im8)))
    else $error("ccr and wrong");
  rp_load_a: assert property (com && op == OP_MOV_RP |=> ps_reg[12:8] == $past(im8[4:0]))
    else $error("rp load wrong");
  br_time_a: assert property (new_br_t |=> busy[*4] ##1 !busy) else $error("taken branch length");
  scan_hi_a: assert property (com && is_bsc |=> acc_reg[15:8] == 8'h00) else $error("scan high byte");
  pfx_lapse_a: assert property (com && !is_pfx |=> !keep_reg && !cmn_reg && !pspv_reg)
    else $error("prefix kept");
  reti_vec_a: assert property (com && op == OP_FRETI && irq_seen |=> pc_reg == VEC_PC)
    else $error("fast return vector");
  chk_on_a: assert property (com && op == OP_CHK_ON |=> chk_reg) else $error("check not on");
  // Scan and data prefix lengths are checked from the issuing edge
  wire new_bsc = start & (pwdata[7:0] == OP_BSCAN);
  wire new_dtb = start & (pwdata[7:0] == OP_PFX_DTB);
  scan_zero_a: assert property (new_bsc && al_zero |=> busy[*3] ##1 !busy)
    else $error("zero scan length");
  scan_len_a: assert property (new_bsc && !al_zero |=> busy[*5] ##1 !busy)
    else $error("scan length");
  dtb_len_a: assert property (new_dtb |=> busy[*2] ##1 !busy) else $error("data prefix length");
endmodule : cie_core

/* File: bench/tb_top.sv */
// Self-checking bench for cie_core: APB master, command issue, state checks.
// Assumes the package register map and a slave that answers every APB access.
`timescale 1ns/1ps
module tb_top;
  import cie_pkg::*;
  logic core_clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, irq_req = 1'b0, pready, pslverr, er;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, v, seed = 32'hA9C5;
  logic [15:0] p, w;
  int mismatches = 0, n_checks = 0;
  // 40 MHz core clock
  always #12.5 core_clk = ~core_clk;
  cie_core i_cie_core (.core_clk(core_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq_req(irq_req));
  // Shift register keeps the random stream repeatable
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // Lowest set bit position scaled by k; a zero word gives 0
  function automatic logic [15:0] scan_exp(input logic [15:0] x, input int k);
    for (int i = 0; i < 16; i++) if (x[i]) return 16'(i * k);
    return 16'h0000;
  endfunction : scan_exp
  task automatic finish_test;
    $display("Checks %0d, mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Spent bound counts as a mismatch and ends the run
  task automatic bound(input int k);
    if (k >= 20) begin
      mismatches++;
      finish_test();
    end
  endtask : bound
  // One transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    bound(k);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask : apb
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rchk
  // Issue a command, then poll busy; the note fixes no polling count
  task automatic cmd(input logic [7:0] op, input logic [7:0] i8, input logic [15:0] i16);
    int k;
    apb(1'b1, CMD_OFS, {i16, i8, op});
    k = 0;
    do begin
      apb(1'b0, STAT_OFS, 32'h0);
      k++;
    end while (rd[0] !== 1'b0 && k < 20);
    bound(k);
  endtask : cmd
  initial begin
    repeat (4) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    rchk(SP_OFS, {16'h0, SP_RST});
    rchk(LIM_OFS, {STACK_LIMIT_UPPER_RST, STACK_LIMIT_LOWER_RST});
    // Unmapped address and read-only limits both refused
    apb(1'b0, 8'h44, 32'h0);
    chk({31'h0, er}, 32'h1);
    apb(1'b1, LIM_OFS, 32'h1);
    chk({31'h0, er}, 32'h1);
    for (int n = 0; n < 8; n++) begin
      seed = lfsr(seed);
      v = seed;
      p = {v[31:24], 1'b0, v[22:16]};
      apb(1'b1, ACC_OFS, v);
      cmd(OP_PUSH_A, 8'h00, 16'h0);
      rchk(SP_OFS, 32'h7E);
      cmd(OP_POP_AH, 8'h00, 16'h0);
      rchk(ACC_OFS, {v[15:0], v[15:0]});
      rchk(SP_OFS, 32'h80);
      apb(1'b1, PS_OFS, {16'h0, p});
      cmd(OP_AND_CCR, v[7:0], 16'h0);
      cmd(OP_OR_CCR, {1'b0, v[14:8]}, 16'h0);
      p[7:0] = (p[7:0] & v[7:0]) | {1'b0, v[14:8]};
      rchk(PS_OFS, {16'h0, p});
      cmd(OP_PUSH_PS, 8'h00, 16'h0);
      apb(1'b1, PS_OFS, 32'h0);
      cmd(OP_POP_PS, 8'h00, 16'h0);
      rchk(PS_OFS, {16'h0, p});
      apb(1'b1, PS_OFS, 32'h0);
      cmd(OP_MOV_RP, v[7:0], 16'h0);
      cmd(OP_MOV_ILM, v[15:8], 16'h0);
      rchk(PS_OFS, {16'h0, v[10:8], v[4:0], 8'h00});
      cmd(OP_SPADJ8, v[7:0], 16'h0);
      rchk(SP_OFS, {16'h0, 16'h0080 + {{8{v[7]}}, v[7:0]}});
      apb(1'b1, SP_OFS, 32'h80);
      // First pass scans a zero word as the corner case
      w = (n == 0) ? 16'h0000 : v[15:0];
      for (int j = 0; j < 3; j++) begin
        apb(1'b1, ACC_OFS, {16'h0, w});
        cmd(OP_BSCAN + 8'(j), 8'h00, 16'h0);
        rchk(ACC_OFS, {16'h0, scan_exp(w, 1 << j)});
        apb(1'b0, PS_OFS, 32'h0);
        chk({31'h0, rd[PS_Z]}, {31'h0, w == 16'h0});
      end
      cmd(OP_BRG_IMM, 8'(n % 5), {8'h00, v[7:0]});
      apb(1'b1, ACC_OFS, {16'h0, v[31:16]});
      cmd(OP_A_BRG, 8'(n % 5), 16'h0);
      rchk(ACC_OFS, {v[31:16], 8'h00, v[7:0]});
      apb(1'b0, PS_OFS, 32'h0);
      chk({30'h0, rd[PS_N], rd[PS_Z]}, {30'h0, v[7], v[7:0] == 8'h00});
    end
    cmd(OP_LD_STACK_LIMIT_LOWER, 8'h00, 16'h0080);
    rchk(LIM_OFS, {STACK_LIMIT_UPPER_RST, 16'h0080});
    cmd(OP_CHK_ON, 8'h00, 16'h0);
    cmd(OP_PUSH_A, 8'h00, 16'h0);
    rchk(SP_OFS, 32'h80);
    apb(1'b0, STAT_OFS, 32'h0);
    chk({30'h0, rd[2:1]}, 32'h3);
    cmd(OP_CHK_OFF, 8'h00, 16'h0);
    cmd(OP_PUSH_A, 8'h00, 16'h0);
    rchk(SP_OFS, 32'h7E);
    // Flag hold covers one instruction only
    apb(1'b1, PS_OFS, 32'h0);
    apb(1'b1, ACC_OFS, 32'h0);
    cmd(OP_PFX_NCC, 8'h00, 16'h0);
    cmd(OP_BSCAN, 8'h00, 16'h0);
    rchk(PS_OFS, 32'h0);
    cmd(OP_BSCAN, 8'h00, 16'h0);
    rchk(PS_OFS, 32'h4);
    cmd(OP_NOP, 8'h00, 16'h0);
    rchk(PS_OFS, 32'h4);
    irq_req <= 1'b1;
    cmd(OP_FRETI, 8'h00, 16'h0);
    rchk(PC_OFS, {16'h0, VEC_PC});
    rchk(SP_OFS, 32'h7E);
    irq_req <= 1'b0;
    cmd(OP_BCOND, 8'h0A, 16'h0010);
    rchk(PC_OFS, {16'h0, VEC_PC + 16'h0010});
    cmd(OP_BCOND, 8'h02, 16'h0010);
    rchk(PC_OFS, {16'h0, VEC_PC + 16'h0010});
    // List round trip in bank 0: pushed highest first, popped lowest first
    apb(1'b1, 8'h84, v);
    apb(1'b1, 8'h88, ~v);
    cmd(OP_PUSH_LST, 8'h06, 16'h0);
    rchk(SP_OFS, 32'h7A);
    apb(1'b1, 8'h84, 32'h0);
    apb(1'b1, 8'h88, 32'h0);
    cmd(OP_POP_LST, 8'h06, 16'h0);
    rchk(8'h84, {16'h0, v[15:0]});
    rchk(8'h88, {16'h0, ~v[15:0]});
    cmd(OP_SPADJ16, 8'h00, 16'h0002);
    rchk(SP_OFS, 32'h80);
    // Common bank for one instruction, then bank 1 again
    cmd(OP_MOV_RP, 8'h01, 16'h0);
    cmd(OP_PFX_CMR, 8'h00, 16'h0);
    cmd(OP_LEA_RW, 8'h03, v[31:16]);
    rchk(8'h8C, {16'h0, v[31:16]});
    cmd(OP_LEA_RWM, 8'h03, v[15:0]);
    rchk(8'hAC, {16'h0, v[15:0]});
    // Space prefixes steer the next stack access only
    apb(1'b1, ACC_OFS, v);
    cmd(OP_PFX_ADB, 8'h00, 16'h0);
    cmd(OP_PUSH_A, 8'h00, 16'h0);
    apb(1'b0, STAT_OFS, 32'h0);
    chk({29'h0, rd[10:8]}, {29'h0, SPC_ADB});
    chk({31'h0, rd[5]}, 32'h0);
    apb(1'b1, ACC_OFS, 32'h0);
    cmd(OP_PFX_DTB, 8'h00, 16'h0);
    cmd(OP_POP_A, 8'h00, 16'h0);
    rchk(ACC_OFS, {16'h0, v[15:0]});
    apb(1'b0, STAT_OFS, 32'h0);
    chk({29'h0, rd[10:8]}, {29'h0, SPC_DTB});
    // Fast return with no interrupt restores from the stack
    apb(1'b1, ACC_OFS, 32'h0000_0004);
    cmd(OP_PUSH_A, 8'h00, 16'h0);
    apb(1'b1, ACC_OFS, 32'h0000_0200);
    cmd(OP_PUSH_A, 8'h00, 16'h0);
    cmd(OP_FRETI, 8'h00, 16'h0);
    rchk(PC_OFS, 32'h200);
    rchk(PS_OFS, 32'h4);
    rchk(SP_OFS, 32'h80);
    cmd(OP_LD_STACK_LIMIT_UPPER, 8'h00, 16'hFF00);
    rchk(LIM_OFS, 32'hFF00_0080);
    cmd(OP_BRG_A, 8'h04, 16'h0);
    rchk(BRGH_OFS, 32'h0);
    cmd(OP_LEA_A, 8'h00, 16'h1234);
    rchk(ACC_OFS, 32'h0200_1234);
    finish_test();
  end
endmodule : tb_top
